// ### design/pmsc_top.sv
// Power supervision status and control register block
//
// Our own choices: the plain strobed port and the register addresses.
`default_nettype none
module pmsc_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic por_n,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic detect_cmp,
	input wire logic warning_cmp,
	input wire logic in_stop,
	input wire logic deep_stop_exit,
	output logic detect_irq,
	output logic detect_reset_req,
	output logic detect_active,
	output logic detect_trip_sel,
	output logic warning_trip_sel,
	output logic ref_buffer_en,
	output logic deep_stop_select,
	output logic watchdog_clk_sel
);
	// ==========================================================
	// Reset release and power-on qualifier
	logic rst_meta_q, rst_sync_n;
	logic por_seen_q;
	logic por_first_q;

	// Async assert, two-flop release
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// Power-on strobe caught by a clocked process with no reset, so it is seen during reset too
	always_ff @(posedge sys_clk)
	begin
		por_seen_q <= por_n;
		por_first_q <= ~por_n & por_seen_q;
	end

	// ==========================================================
	// Comparator synchronisation
	logic [1:0] cmp_s;
	logic det_lvl, warn_lvl;
	pmsc_sync u_sync (
		.clk(sys_clk),
		.rst_n(rst_sync_n),
		.ce(clk_en),
		.async_in({warning_cmp, detect_cmp}),
		.sync_out(cmp_s)
	);
	assign det_lvl = cmp_s[0];
	assign warn_lvl = cmp_s[1];

	// ==========================================================
	// Write decode
	logic wr_det, wr_warn, wr_opt;
	assign wr_det = wr_en && (addr == pmsc_pkg::PMSC_OFF_DET);
	assign wr_warn = wr_en && (addr == pmsc_pkg::PMSC_OFF_WARN);
	assign wr_opt = wr_en && (addr == pmsc_pkg::PMSC_OFF_OPT);

	// ==========================================================
	// Detect control register
	logic dflag_q, die_q, dre_q, dse_q, den_q, buf_q;
	logic det_event;
	// Detection runs when enabled, and in stop only if stop enable
	assign detect_active = den_q && (!in_stop || dse_q);
	assign det_event = detect_active && det_lvl;

	// Flag: set wins over acknowledge in the same cycle
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			dflag_q <= 1'b0;
		else if (clk_en)
		begin
			if (det_event)
				dflag_q <= 1'b1;
			else if (wr_det && wdata[pmsc_pkg::PMSC_B_DACK])
				dflag_q <= 1'b0;
		end
	end

	// Plain read/write control bits; bit 1 ignored, software writes 0
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			die_q <= pmsc_pkg::PMSC_RST_DET[pmsc_pkg::PMSC_B_DIE];
			dre_q <= pmsc_pkg::PMSC_RST_DET[pmsc_pkg::PMSC_B_DRE];
			dse_q <= pmsc_pkg::PMSC_RST_DET[pmsc_pkg::PMSC_B_DSE];
			den_q <= pmsc_pkg::PMSC_RST_DET[pmsc_pkg::PMSC_B_DEN];
			buf_q <= pmsc_pkg::PMSC_RST_DET[pmsc_pkg::PMSC_B_BUF];
		end
		else if (clk_en && wr_det)
		begin
			die_q <= wdata[pmsc_pkg::PMSC_B_DIE];
			dre_q <= wdata[pmsc_pkg::PMSC_B_DRE];
			dse_q <= wdata[pmsc_pkg::PMSC_B_DSE];
			den_q <= wdata[pmsc_pkg::PMSC_B_DEN];
			buf_q <= wdata[pmsc_pkg::PMSC_B_BUF];
		end
	end

	assign detect_irq = dflag_q && die_q;
	assign detect_reset_req = dflag_q && dre_q && den_q;
	assign ref_buffer_en = buf_q;

	// ==========================================================
	// Warning and stop control register
	logic wflag_q, rflag_q, dtrip_q, wtrip_q, deep_q, deep_wr_q;

	// Warning flag sticky; ack only while no warning present
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			wflag_q <= pmsc_pkg::PMSC_RST_WARN[pmsc_pkg::PMSC_B_WFLAG];
		else if (clk_en)
		begin
			if (warn_lvl)
				wflag_q <= 1'b1;
			else if (wr_warn && wdata[pmsc_pkg::PMSC_B_WACK])
				wflag_q <= 1'b0;
		end
	end

	// Recovery flag: exit strobe wins over acknowledge
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			rflag_q <= pmsc_pkg::PMSC_RST_WARN[pmsc_pkg::PMSC_B_RFLAG];
		else if (clk_en)
		begin
			if (deep_stop_exit)
				rflag_q <= 1'b1;
			else if (wr_warn && wdata[pmsc_pkg::PMSC_B_RACK])
				rflag_q <= 1'b0;
		end
	end

	// Trip selects survive every reset except power-on
	always_ff @(posedge sys_clk)
	begin
		if (por_first_q)
		begin
			dtrip_q <= pmsc_pkg::PMSC_RST_WARN[pmsc_pkg::PMSC_B_DTRIP];
			wtrip_q <= pmsc_pkg::PMSC_RST_WARN[pmsc_pkg::PMSC_B_WTRIP];
		end
		else if (clk_en && rst_sync_n && wr_warn)
		begin
			dtrip_q <= wdata[pmsc_pkg::PMSC_B_DTRIP];
			wtrip_q <= wdata[pmsc_pkg::PMSC_B_WTRIP];
		end
	end
	assign detect_trip_sel = dtrip_q;
	assign warning_trip_sel = wtrip_q;

	// Deep stop select: first write after reset sticks
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			deep_q <= pmsc_pkg::PMSC_RST_WARN[pmsc_pkg::PMSC_B_DEEP];
			deep_wr_q <= 1'b0;
		end
		else if (clk_en && wr_warn && !deep_wr_q)
		begin
			deep_q <= wdata[pmsc_pkg::PMSC_B_DEEP];
			deep_wr_q <= 1'b1;
		end
	end
	assign deep_stop_select = deep_q;

	// ==========================================================
	// Options register: write-once watchdog clock select
	logic wdclk_q, wdclk_wr_q;
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			wdclk_q <= pmsc_pkg::PMSC_RST_OPT[pmsc_pkg::PMSC_B_WDCLK];
			wdclk_wr_q <= 1'b0;
		end
		else if (clk_en && wr_opt && !wdclk_wr_q)
		begin
			wdclk_q <= wdata[pmsc_pkg::PMSC_B_WDCLK];
			wdclk_wr_q <= 1'b1;
		end
	end
	// 0 picks the slow internal clock, 1 the bus clock
	assign watchdog_clk_sel = wdclk_q;

	// ==========================================================
	// Read path, data one cycle after the strobe
	logic [7:0] rd_d;
	always_comb
	begin
		rd_d = 8'h00;
		case (addr)
			pmsc_pkg::PMSC_OFF_DET:
			begin
				rd_d[pmsc_pkg::PMSC_B_DFLAG] = dflag_q;
				rd_d[pmsc_pkg::PMSC_B_DIE] = die_q;
				rd_d[pmsc_pkg::PMSC_B_DRE] = dre_q;
				rd_d[pmsc_pkg::PMSC_B_DSE] = dse_q;
				rd_d[pmsc_pkg::PMSC_B_DEN] = den_q;
				rd_d[pmsc_pkg::PMSC_B_BUF] = buf_q;
			end
			pmsc_pkg::PMSC_OFF_WARN:
			begin
				rd_d[pmsc_pkg::PMSC_B_WFLAG] = wflag_q;
				rd_d[pmsc_pkg::PMSC_B_DTRIP] = dtrip_q;
				rd_d[pmsc_pkg::PMSC_B_WTRIP] = wtrip_q;
				rd_d[pmsc_pkg::PMSC_B_RFLAG] = rflag_q;
				rd_d[pmsc_pkg::PMSC_B_DEEP] = deep_q;
			end
			pmsc_pkg::PMSC_OFF_OPT:
				rd_d[pmsc_pkg::PMSC_B_WDCLK] = wdclk_q;
			default:
				rd_d = 8'h00; // Unmapped reads return zero
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			rdata <= 8'h00;
		else if (clk_en)
			rdata <= rd_en ? rd_d : 8'h00;
	end

	// ==========================================================
	// Checks
	property p_det_set;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(clk_en && det_event) |=> dflag_q;
	endproperty
	a_det_set: assert property (p_det_set) else $error("detect flag not set");

	property p_det_ack;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(clk_en && wr_det && wdata[pmsc_pkg::PMSC_B_DACK] && !det_event) |=> !dflag_q;
	endproperty
	a_det_ack: assert property (p_det_ack) else $error("detect ack ignored");

	property p_irq;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		detect_irq == (dflag_q && die_q);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");

	property p_rst_gate;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		!den_q |-> !detect_reset_req;
	endproperty
	a_rst_gate: assert property (p_rst_gate) else $error("reset without enable");

	property p_stop;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(in_stop && !dse_q) |-> !detect_active;
	endproperty
	a_stop: assert property (p_stop) else $error("detect active in stop");

	property p_warn_hold;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(clk_en && warn_lvl) |=> wflag_q;
	endproperty
	a_warn_hold: assert property (p_warn_hold) else $error("warning not held");

	property p_rec_set;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(clk_en && deep_stop_exit) |=> rflag_q;
	endproperty
	a_rec_set: assert property (p_rec_set) else $error("recovery flag not set");

	property p_once;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		wdclk_wr_q |=> $stable(wdclk_q);
	endproperty
	a_once: assert property (p_once) else $error("write-once changed");

	// Deep stop select must also lock after its first write
	property p_deep_once;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		deep_wr_q |=> $stable(deep_q);
	endproperty
	a_deep_once: assert property (p_deep_once) else $error("deep select changed");

	property p_warn_ack;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(clk_en && wr_warn && wdata[pmsc_pkg::PMSC_B_WACK] && !warn_lvl) |=> !wflag_q;
	endproperty
	a_warn_ack: assert property (p_warn_ack) else $error("warning ack ignored");

	property p_rec_ack;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(clk_en && wr_warn && wdata[pmsc_pkg::PMSC_B_RACK] && !deep_stop_exit) |=> !rflag_q;
	endproperty
	a_rec_ack: assert property (p_rec_ack) else $error("recovery ack ignored");

	// A disabled detector must never raise the flag on its own
	property p_det_gate;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(clk_en && !dflag_q && !detect_active) |=> !dflag_q;
	endproperty
	a_det_gate: assert property (p_det_gate) else $error("flag set while off");

	property p_rd_idle;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(clk_en && !rd_en) |=> (rdata == 8'h00);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");

	property p_rd_ack;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(clk_en && rd_en) |=> (rdata[pmsc_pkg::PMSC_B_DACK] == 1'b0);
	endproperty
	a_rd_ack: assert property (p_rd_ack) else $error("ack bit read back");

	// Power-on can be seen inside the reset window, so no disable here
	property p_trip_por;
		@(posedge sys_clk)
		por_first_q |=> (!dtrip_q && !wtrip_q);
	endproperty
	a_trip_por: assert property (p_trip_por) else $error("trip selects kept");

	property p_wd_first;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		(clk_en && wr_opt && !wdclk_wr_q) |=> (wdclk_q == $past(wdata[pmsc_pkg::PMSC_B_WDCLK]));
	endproperty
	a_wd_first: assert property (p_wd_first) else $error("first write lost");
endmodule
`default_nettype wire

// ### design/pmsc_pkg.sv
// Package of offsets, field positions and reset values for the power status block
// Operation
// - Detect event sets detect flag when enabled
// - Detect ack write clears flag, reads zero
// - Interrupt request while flag and enable set
// - Flag forces chip reset when enabled
// - Stop enable keeps detection running in stop
// - Detect enable gates flag, reset, stop
// - Bit zero drives reference buffer enable
// - Warning flag sets below trip, sticky
// - Warning ack clears only without warning
// - Detect trip select picks low or high
// - Warning trip select picks low or high
// - Deep stop exit sets recovery flag
// - Recovery ack write clears recovery flag
// - Deep stop select picks stop kind
// - Write-once controls take first write only
// - Watchdog clock select: slow or bus
`default_nettype none
package pmsc_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [1:0] PMSC_OFF_DET = 2'h0;
	localparam logic [1:0] PMSC_OFF_WARN = 2'h1;
	localparam logic [1:0] PMSC_OFF_OPT = 2'h2;
	// ==========================================================
	// Detect control fields
	localparam int PMSC_B_DFLAG = 7;
	localparam int PMSC_B_DACK = 6;
	localparam int PMSC_B_DIE = 5;
	localparam int PMSC_B_DRE = 4;
	localparam int PMSC_B_DSE = 3;
	localparam int PMSC_B_DEN = 2;
	localparam int PMSC_B_BUF = 0;
	// ==========================================================
	// Warning and stop control fields
	localparam int PMSC_B_WFLAG = 7;
	localparam int PMSC_B_WACK = 6;
	localparam int PMSC_B_DTRIP = 5;
	localparam int PMSC_B_WTRIP = 4;
	localparam int PMSC_B_RFLAG = 3;
	localparam int PMSC_B_RACK = 2;
	localparam int PMSC_B_DEEP = 0;
	// ==========================================================
	// Options field and reset values
	localparam int PMSC_B_WDCLK = 1;
	localparam logic [7:0] PMSC_RST_DET = 8'h1C;
	localparam logic [7:0] PMSC_RST_WARN = 8'h00;
	localparam logic [7:0] PMSC_RST_OPT = 8'h02;
	localparam int PMSC_SYNC_STAGES = 2;
endpackage
`default_nettype wire

// ### design/pmsc_sync.sv
// Two-flop synchroniser for the analog comparator outputs
`default_nettype none
module pmsc_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [1:0] async_in,
	output logic [1:0] sync_out
);
	logic [1:0] meta_q;
	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= 2'h0;
			sync_out <= 2'h0;
		end
		else if (ce)
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### bench/pmsc_top_bench.sv
// Self-checking bench for the power supervision register block
`default_nettype none
module pmsc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Design signals and bench state
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic por_n = 1'h1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_en = 1'h0;
	logic rd_en = 1'h0;
	logic clk_en = 1'h1;
	logic detect_cmp = 1'h0;
	logic warning_cmp = 1'h0;
	logic in_stop = 1'h0;
	logic deep_stop_exit = 1'h0;
	logic [7:0] rdata;
	wire logic [7:0] outs;
	int fail_count = 0;
	int checked = 0;
	// Model: stored detect bits, flags, trip selects, write-once locks
	logic [7:0] m_det;
	logic m_dflag, m_wflag, m_rflag, m_dtrip, m_wtrip, m_deep, m_deep_lk, m_wd, m_wd_lk;

	// Free-running 50 MHz clock
	always #10 sys_clk = ~sys_clk;

	pmsc_top u_dut (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.por_n(por_n),
		.addr(addr),
		.wdata(wdata),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rdata(rdata),
		.detect_cmp(detect_cmp),
		.warning_cmp(warning_cmp),
		.in_stop(in_stop),
		.deep_stop_exit(deep_stop_exit),
		.detect_irq(outs[7]),
		.detect_reset_req(outs[6]),
		.detect_active(outs[5]),
		.detect_trip_sel(outs[4]),
		.warning_trip_sel(outs[3]),
		.ref_buffer_en(outs[2]),
		.deep_stop_select(outs[1]),
		.watchdog_clk_sel(outs[0])
	);

	// ==========================================================
	// Model and compare helpers
	function automatic logic [7:0] exp_rd(input logic [1:0] a);
		case (a)
			2'h0: exp_rd = {m_dflag, 1'h0, m_det[5:2], 1'h0, m_det[0]};
			2'h1: exp_rd = {m_wflag, 1'h0, m_dtrip, m_wtrip, m_rflag, 2'h0, m_deep};
			2'h2: exp_rd = {6'h00, m_wd, 1'h0};
			default: exp_rd = 8'h00;
		endcase
	endfunction

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Read, check data in the following cycle, then check it drops to zero
	task automatic rd_chk(input logic [1:0] a);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge sys_clk);
		rd_en <= 1'h0;
		#1;
		cmp(rdata, exp_rd(a));
		@(posedge sys_clk);
		#1;
		cmp(rdata, 8'h00);
	endtask

	// Settled outputs against the model's view of the control bits
	task automatic chk_out();
		#1;
		cmp(outs, {m_dflag & m_det[5], m_dflag & m_det[4] & m_det[2],
			m_det[2] & (!in_stop | m_det[3]), m_dtrip, m_wtrip, m_det[0], m_deep, m_wd});
	endtask

	// One-cycle write; the model follows the same edge
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'h1;
		@(posedge sys_clk);
		wr_en <= 1'h0;
		// A frozen block takes nothing
		if (!clk_en)
			return;
		if (a == 2'h0)
		begin
			m_det = d & 8'h3D;
			if (d[6]) m_dflag = 1'h0;
		end
		if (a == 2'h1)
		begin
			if (d[6] && !warning_cmp) m_wflag = 1'h0;
			if (d[2]) m_rflag = 1'h0;
			m_dtrip = d[5];
			m_wtrip = d[4];
			if (!m_deep_lk) {m_deep, m_deep_lk} = {d[0], 1'h1};
		end
		if (a == 2'h2 && !m_wd_lk) {m_wd, m_wd_lk} = {d[1], 1'h1};
	endtask

	// Reset for ten cycles, optionally with a power-on indication
	task automatic do_reset(input logic por);
		rst_n <= 1'h0;
		por_n <= !por;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'h1;
		por_n <= 1'h1;
		repeat (3) @(posedge sys_clk);
		m_det = 8'h1C;
		{m_dflag, m_wflag, m_rflag, m_deep, m_deep_lk, m_wd, m_wd_lk} = 7'h02;
		if (por) {m_dtrip, m_wtrip} = 2'h0;
	endtask

	// Comparator pulse long enough to pass the synchroniser
	task automatic det_event();
		detect_cmp <= 1'h1;
		repeat (5) @(posedge sys_clk);
		detect_cmp <= 1'h0;
		repeat (5) @(posedge sys_clk);
		if (m_det[2]) m_dflag = 1'h1;
	endtask

	task automatic final_report();
		if (fail_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		logic [1:0] a;
		logic [7:0] d;
		int r;
		r = $urandom(80);
		@(posedge sys_clk);
		do_reset(1'h1);
		for (int k = 0; k < 4; k++) rd_chk(k[1:0]);
		chk_out();
		// Second writes to write-once bits must be ignored
		wr(2'h1, 8'h31);
		wr(2'h2, 8'h00);
		wr(2'h1, 8'h30);
		wr(2'h2, 8'h02);
		rd_chk(2'h2);
		chk_out();
		// Plain reset keeps trip selects, reopens write-once bits
		do_reset(1'h0);
		rd_chk(2'h1);
		chk_out();
		wr(2'h0, 8'h3D);
		det_event();
		rd_chk(2'h0);
		chk_out();
		in_stop <= 1'h1;
		wr(2'h0, 8'h35);
		chk_out();
		in_stop <= 1'h0;
		wr(2'h0, 8'h2D);
		chk_out();
		wr(2'h0, 8'h40);
		rd_chk(2'h0);
		chk_out();
		det_event();
		rd_chk(2'h0);
		// Warning ack is refused while the condition persists
		warning_cmp <= 1'h1;
		repeat (5) @(posedge sys_clk);
		m_wflag = 1'h1;
		wr(2'h1, 8'h40);
		rd_chk(2'h1);
		warning_cmp <= 1'h0;
		repeat (5) @(posedge sys_clk);
		rd_chk(2'h1);
		wr(2'h1, 8'h40);
		rd_chk(2'h1);
		deep_stop_exit <= 1'h1;
		@(posedge sys_clk);
		deep_stop_exit <= 1'h0;
		@(posedge sys_clk);
		m_rflag = 1'h1;
		rd_chk(2'h1);
		wr(2'h1, 8'h04);
		rd_chk(2'h1);
		// Clock enable low: a write must leave every bit alone
		clk_en <= 1'h0;
		wr(2'h1, 8'h30);
		clk_en <= 1'h1;
		rd_chk(2'h1);
		chk_out();
		// Random traffic, unmapped offset included
		for (int i = 0; i < 60; i++)
		begin
			a = 2'($urandom % 4);
			d = 8'($urandom);
			if (a == 2'h0) d[1] = 1'h0;
			in_stop <= 1'($urandom % 2);
			wr(a, d);
			rd_chk(2'($urandom % 4));
			chk_out();
		end
		final_report();
	end

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		final_report();
	end
endmodule
`default_nettype wire
